// [pkg/swpc_pkg.sv]
// Package for the sleep/wake power controller: register map, fields,
// reset values, state encoding and timing counts.
// Assumes a single 10 MHz clock and a plain synchronous register port.
package swpc_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam logic [7:0] ADDR_CNT_LO   = 8'h10;
   localparam logic [7:0] ADDR_CNT_HI   = 8'h14;
   localparam logic [7:0] ADDR_WAKE_LO  = 8'h18;
   localparam logic [7:0] ADDR_WAKE_HI  = 8'h1C;
   localparam logic [7:0] ADDR_INCR     = 8'h20;
   localparam logic [7:0] ADDR_DSM_BASE = 8'h80;  // 32 words of deep-sleep memory
   localparam logic [7:0] ADDR_DSM_TOP  = 8'hFC;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_SLEEP_BIT    = 0;  // write one: sleep request
   localparam int CTRL_PIN_EN_BIT   = 1;
   localparam int CTRL_PIN_POL_BIT  = 2;  // 1: wake on rising edge, 0: wake on falling edge
   localparam int CTRL_TIMER_EN_BIT = 3;
   localparam int CTRL_USB_EN_BIT   = 4;
   localparam int CTRL_SLOW_EN_BIT  = 5;  // move counter to slow osc in sleep
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // Interrupt status bits
   localparam int IRQ_ASLEEP_BIT = 0;
   localparam int IRQ_AWAKE_BIT  = 1;
   localparam int IRQ_PGOOD_BIT  = 2;
   localparam int IRQ_TIMER_BIT  = 3;
   localparam int IRQ_W          = 4;

   // Counter and memory shape
   localparam int CNT_W       = 64;
   localparam int DSM_BYTES   = 128;
   localparam int DSM_WORDS   = DSM_BYTES / 4;
   localparam logic [31:0] INCR_RESET = 32'h0000_0140;  // plain default

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ      = 10_000_000;
   localparam int SLOW_HZ     = 31_250;
   localparam int SLOW_DIV    = CLK_HZ / SLOW_HZ;  // 320 clocks per slow tick
   localparam int SETTLE_NS   = 1_000;             // settle time per transition step
   localparam int SETTLE_CYC  = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;

   // ----------------------------------------------------------------
   // Power states, Gray coded along the path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_POWER_UP  = 3'b000,
      ST_CLK_ON    = 3'b001,
      ST_AWAKE     = 3'b011,
      ST_CLK_OFF   = 3'b010,
      ST_PWR_DOWN  = 3'b110,
      ST_ASLEEP    = 3'b111
   } swpc_state_t;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } swpc_req_t;

   // Power domain controls
   typedef struct packed {
      logic node_power;    // digital node and peripherals powered
      logic clk_enable;
      logic wdog_enable;
      logic sys_reset;     // pulse on power-good loss in a transition
   } swpc_pwr_t;

endpackage

// [src/swpc_ctrl.sv]
// Sleep/wake power controller with real-time counter, deep-sleep memory
// and interrupt status. Assumes one 10 MHz clock, inputs synchronous to it,
// and a register master that never issues a sleep request outside awake.
//
// Function
// - Sleep quiescent, awake running, via transition states
// - Sleep request from register or USB
// - Wake from USB, pin or timer
// - Wake stimuli acted on only when asleep
// - Wake during entry held until asleep
// - Wake on pin edge, counter match, USB
// - Sleep powers node down, awake runs all
// - Awake: counter increments each main tick
// - Optionally switch counter to slow oscillator asleep
// - Slow ticks add programmable increment
// - 128-byte deep-sleep memory kept asleep
// - Power-good loss in transition issues reset
// - Watchdog enabled only while awake
`timescale 1ns/1ns
module swpc_ctrl
   import swpc_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Register port
   input  wire swpc_pkg::swpc_req_t  req,
   output logic [31:0]               rdata,
   // Partners
   input  wire logic                 usb_standby_enter,
   input  wire logic                 usb_standby_exit,
   input  wire logic                 wake_pin,
   input  wire logic                 power_good,
   // Power outputs
   output swpc_pkg::swpc_pwr_t       pwr,
   output swpc_pkg::swpc_state_t     state_out,
   output logic                      irq
);
   import swpc_pkg::*;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   swpc_state_t          state;
   swpc_state_t          next_state;
   logic [5:0]           ctrl;
   logic [IRQ_W-1:0]     irq_stat;
   logic [IRQ_W-1:0]     irq_mask;
   logic [CNT_W-1:0]     count;
   logic [CNT_W-1:0]     wake_val;
   logic [31:0]          incr;
   logic [31:0]          dsm [DSM_WORDS];
   logic [8:0]           slow_div;
   logic [15:0]          settle;
   logic                 wake_pend;
   logic                 pin_d;
   logic                 reset_pulse;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   // Address match used by the write path; the read mux decodes with a case
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   wire logic dsm_sel      = req.addr >= ADDR_DSM_BASE;
   wire logic [4:0] dsm_ix = req.addr[6:2];
   wire logic wr_ctrl      = req.wr && hit(req.addr, ADDR_CTRL);
   wire logic sleep_sw     = wr_ctrl && req.wdata[CTRL_SLEEP_BIT];
   wire logic sleep_req    = (sleep_sw || usb_standby_enter)
                             && state == ST_AWAKE;
   wire logic is_asleep    = state == ST_ASLEEP;
   wire logic in_entry     = state == ST_CLK_OFF || state == ST_PWR_DOWN;
   wire logic in_trans     = state != ST_AWAKE && state != ST_ASLEEP;
   wire logic settled      = settle == 16'h0000;

   // Pin edge in the programmed direction
   wire logic pin_edge  = ctrl[CTRL_PIN_POL_BIT] ? (wake_pin && !pin_d)
                                                 : (!wake_pin && pin_d);
   wire logic pin_wake  = ctrl[CTRL_PIN_EN_BIT] && pin_edge;
   wire logic timer_hit = ctrl[CTRL_TIMER_EN_BIT] && count == wake_val;
   wire logic usb_wake  = ctrl[CTRL_USB_EN_BIT] && usb_standby_exit;
   wire logic wake_stim = pin_wake || timer_hit || usb_wake;
   wire logic wake_go   = is_asleep && (wake_stim || wake_pend);

   // Slow clock enable, and which tick source drives the counter
   wire logic slow_tick = slow_div == 9'((SLOW_DIV) - 1);
   wire logic on_slow   = ctrl[CTRL_SLOW_EN_BIT] && !(state == ST_AWAKE);
   wire logic pg_loss   = in_trans && !power_good;

   // ----------------------------------------------------------------
   // State sequencing
   // ----------------------------------------------------------------
   // Each transition step waits for the settle count
   always_comb begin
      next_state = state;
      unique case (state)
         ST_POWER_UP: if (settled) next_state = ST_CLK_ON;
         ST_CLK_ON:   if (settled) next_state = ST_AWAKE;
         ST_AWAKE:    if (sleep_req) next_state = ST_CLK_OFF;
         ST_CLK_OFF:  if (settled) next_state = ST_PWR_DOWN;
         ST_PWR_DOWN: if (settled) next_state = ST_ASLEEP;
         ST_ASLEEP:   if (wake_go) next_state = ST_POWER_UP;
         default:     next_state = ST_POWER_UP;
      endcase
      if (pg_loss) begin
         next_state = ST_POWER_UP;
      end
   end

   // State register and settle timer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state  <= ST_POWER_UP;
         settle <= 16'(SETTLE_CYC);
      end else begin
         state  <= next_state;
         settle <= (next_state != state) ? 16'(SETTLE_CYC)
                 : (settled ? settle : settle - 16'h0001);
      end
   end

   // Wake stimulus during sleep entry is remembered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake_pend <= 1'b0;
      end else if (in_entry && wake_stim) begin
         wake_pend <= 1'b1;
      end else if (state == ST_AWAKE || wake_go) begin
         wake_pend <= 1'b0;
      end
   end

   // Reset pulse and pin history
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reset_pulse <= 1'b0;
         pin_d       <= 1'b0;
      end else begin
         reset_pulse <= pg_loss;
         pin_d       <= wake_pin;
      end
   end

   // ----------------------------------------------------------------
   // Real-time counter
   // ----------------------------------------------------------------
   // Slow oscillator divider: an enable pulse every 320 clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slow_div <= 9'h000;
      end else begin
         slow_div <= slow_tick ? 9'h000 : slow_div + 9'h001;
      end
   end

   // Main tick adds one, slow tick adds the programmed increment
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= 64'h0;
      end else if (!on_slow) begin
         count <= count + 64'h1;
      end else if (slow_tick) begin
         count <= count + {32'h0, incr};
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Sleep bit self-clears; it is only a request strobe
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl     <= CTRL_RESET;
         irq_mask <= 4'h0;
         wake_val <= 64'hFFFF_FFFF_FFFF_FFFF;
         incr     <= INCR_RESET;
      end else if (req.wr) begin
         if (wr_ctrl) ctrl <= {req.wdata[5:1], 1'b0};
         if (hit(req.addr, ADDR_IRQ_MASK)) irq_mask <= req.wdata[IRQ_W-1:0];
         if (hit(req.addr, ADDR_WAKE_LO)) wake_val[31:0] <= req.wdata;
         if (hit(req.addr, ADDR_WAKE_HI)) wake_val[63:32] <= req.wdata;
         if (hit(req.addr, ADDR_INCR)) incr <= req.wdata;
      end
   end

   // Deep-sleep memory has no reset; it keeps contents through sleep
   always_ff @(posedge clk) begin
      if (req.wr && dsm_sel) begin
         dsm[dsm_ix] <= req.wdata;
      end
   end

   // Sticky events; a set in the clear cycle wins
   wire logic [IRQ_W-1:0] ev = {timer_hit && is_asleep, reset_pulse,
                                state == ST_CLK_ON && next_state == ST_AWAKE,
                                state == ST_PWR_DOWN && next_state == ST_ASLEEP};
   wire logic [IRQ_W-1:0] w1c = (req.wr && hit(req.addr, ADDR_IRQ_STAT))
                                ? req.wdata[IRQ_W-1:0] : 4'h0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat <= 4'h0;
      end else begin
         irq_stat <= (irq_stat & ~w1c) | ev;
      end
   end

   // Read mux, registered so data stand the cycle after the strobe
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (dsm_sel) begin
         rd_mux = dsm[dsm_ix];
      end else begin
         unique case (req.addr)
            ADDR_CTRL:     rd_mux = {26'h0, ctrl};
            ADDR_STATUS:   rd_mux = {27'h0, wake_pend, on_slow, state};
            ADDR_IRQ_STAT: rd_mux = {28'h0, irq_stat};
            ADDR_IRQ_MASK: rd_mux = {28'h0, irq_mask};
            ADDR_CNT_LO:   rd_mux = count[31:0];
            ADDR_CNT_HI:   rd_mux = count[63:32];
            ADDR_WAKE_LO:  rd_mux = wake_val[31:0];
            ADDR_WAKE_HI:  rd_mux = wake_val[63:32];
            ADDR_INCR:     rd_mux = incr;
            default:       rd_mux = 32'h0;  // Unmapped reads zero
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0;
      end else begin
         rdata <= req.rd ? rd_mux : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Node powered everywhere except the sleep-side states
   assign pwr.node_power  = !(state == ST_PWR_DOWN || is_asleep);
   assign pwr.clk_enable  = state == ST_AWAKE || state == ST_CLK_ON
                            || state == ST_CLK_OFF;
   assign pwr.wdog_enable = state == ST_AWAKE;
   assign pwr.sys_reset   = reset_pulse;
   assign state_out       = state;
   assign irq             = |(irq_stat & irq_mask);

endmodule

// [bench/swpc_assertions.sv]
// Checker for the power controller, bound to its ports.
// Assumes one clock and power_good steady unless a test drops it.
`timescale 1ns/1ns
module swpc_assertions
   import swpc_pkg::*;
(
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  nrst,
   // Register port
   input wire swpc_pkg::swpc_req_t   req,
   input wire logic [31:0]           rdata,
   // Partners
   input wire logic                  usb_standby_enter,
   input wire logic                  usb_standby_exit,
   input wire logic                  wake_pin,
   input wire logic                  power_good,
   // Power outputs
   input wire swpc_pkg::swpc_pwr_t   pwr,
   input wire swpc_pkg::swpc_state_t state_out,
   input wire logic                  irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Transition states and a register sleep request
   wire logic tr  = state_out inside {ST_POWER_UP, ST_CLK_ON, ST_CLK_OFF, ST_PWR_DOWN};
   wire logic slp = req.wr && req.addr == ADDR_CTRL && req.wdata[CTRL_SLEEP_BIT];

   wdog_awake_a: assert property (pwr.wdog_enable == (state_out == ST_AWAKE))
      else $error("watchdog enable wrong");
   node_off_a: assert property (state_out == ST_ASLEEP |-> !pwr.node_power && !pwr.clk_enable)
      else $error("node powered in sleep");
   clk_run_a: assert property (pwr.clk_enable == (state_out inside {ST_CLK_ON, ST_AWAKE, ST_CLK_OFF}))
      else $error("clock enable wrong");
   sleep_go_a: assert property (state_out == ST_AWAKE && (usb_standby_enter || slp) |=> state_out == ST_CLK_OFF)
      else $error("sleep request not taken");
   awake_stay_a: assert property (state_out == ST_AWAKE && !usb_standby_enter && !slp |=> state_out == ST_AWAKE)
      else $error("left awake without request");
   pgood_rst_a: assert property (tr && !power_good |=> state_out == ST_POWER_UP && pwr.sys_reset)
      else $error("no reset on supply loss");
   asleep_exit_a: assert property (state_out == ST_ASLEEP |=> state_out inside {ST_ASLEEP, ST_POWER_UP})
      else $error("bad exit from sleep");
   entry_path_a: assert property (@(posedge clk) disable iff (!nrst || !power_good)
      state_out == ST_CLK_OFF && $past(state_out) == ST_AWAKE |-> ##10 state_out == ST_CLK_OFF
      ##1 state_out == ST_PWR_DOWN ##10 state_out == ST_PWR_DOWN ##1 state_out == ST_ASLEEP)
      else $error("sleep entry path wrong");
   wake_path_a: assert property (@(posedge clk) disable iff (!nrst || !power_good)
      state_out == ST_POWER_UP && $past(state_out) == ST_ASLEEP |-> ##11 state_out == ST_CLK_ON
      ##11 state_out == ST_AWAKE)
      else $error("wake path wrong");
endmodule

// [bench/swpc_partner.sv]
// Model of the USB block, wake pin and supplies facing the controller.
// Assumes the bench commands it; USB standby asks only while awake.
`timescale 1ns/1ns
module swpc_partner
   import swpc_pkg::*;
(
   // Commands from the bench
   input  wire logic                  ask_sleep,
   input  wire logic                  ask_wake,
   input  wire logic                  pin_level,
   input  wire logic                  supply_ok,
   // Device side
   input  wire swpc_pkg::swpc_state_t state_out,
   output logic                       usb_standby_enter,
   output logic                       usb_standby_exit,
   output logic                       wake_pin,
   output logic                       power_good
);
   // Standby entry is held back outside awake; supplies stay good unless a test drops one
   assign usb_standby_enter = ask_sleep && state_out == ST_AWAKE;
   assign usb_standby_exit  = ask_wake;
   assign wake_pin          = pin_level;
   assign power_good        = supply_ok;
endmodule

// [bench/tb.sv]
// Self-checking bench for the power controller.
// Assumes swpc_ctrl, the partner model and the checker.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module tb;
   import swpc_pkg::*;
   logic        clk, nrst, ask_sleep, ask_wake, pin_level, supply_ok, irq;
   logic        usb_standby_enter, usb_standby_exit, wake_pin, power_good;
   logic [31:0] rdata, d, d2, incr;
   swpc_req_t   req;
   swpc_pwr_t   pwr;
   swpc_state_t state_out;
   int          num_errors, n_checks, n, cyc, t0;
   logic [31:0] mdl [int];
   logic [7:0]  ra [5] = '{ADDR_CTRL, ADDR_STATUS, ADDR_INCR, ADDR_WAKE_HI, 8'h40};
   logic [31:0] re [5] = '{32'h0, 32'h3, INCR_RESET, 32'hFFFFFFFF, 32'h0};

   swpc_ctrl DUT (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .usb_standby_enter(usb_standby_enter),
      .usb_standby_exit(usb_standby_exit), .wake_pin(wake_pin), .power_good(power_good), .pwr(pwr),
      .state_out(state_out), .irq(irq));
   swpc_partner far (.ask_sleep(ask_sleep), .ask_wake(ask_wake), .pin_level(pin_level), .supply_ok(supply_ok),
      .state_out(state_out), .usb_standby_enter(usb_standby_enter), .usb_standby_exit(usb_standby_exit),
      .wake_pin(wake_pin), .power_good(power_good));

   // Clock and cycle count
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc++;

   // ------------------------------------------------------------
   // Bus and partner tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) req <= '{a, v, 1'b1, 1'b0};
      @(posedge clk) req <= '{a, v, 1'b0, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk) req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk) req <= '{a, 32'h0, 1'b0, 1'b0};
      #1 v = rdata;
   endtask
   task automatic usb(input bit w);
      @(posedge clk) {ask_wake, ask_sleep} <= {w, !w};
      @(posedge clk) {ask_wake, ask_sleep} <= 2'b00;
   endtask
   // Bounded wait, cycles counted in n
   task automatic wait_st(input swpc_state_t st, input int mx);
      n = 0;
      do begin @(negedge clk); n++; end while (state_out !== st && n < mx);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard, far beyond the whole sequence
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize();
   end

   initial begin
      {ask_sleep, ask_wake, pin_level} = 3'b000;
      supply_ok = 1;
      req = '0;
      nrst = 0;
      void'($urandom(32'h02A8));
      repeat (20) @(posedge clk);
      nrst <= 1;
      wait_st(ST_AWAKE, 60);
      `CHK("boot", 1'b1, n < 60)
      foreach (ra[i]) begin
         rd(ra[i], d);
         `CHK("reset value", re[i], d)
      end
      rd(ADDR_CNT_LO, d);
      rd(ADDR_CNT_LO, d2);
      `CHK("fast count", d + 32'h2, d2)
      for (int i = 0; i < 4; i++) begin
         mdl[i] = $urandom;
         wr(ADDR_DSM_BASE + 8'(4 * i), mdl[i]);
      end
      // Pin edge while awake must be forgotten
      wr(ADDR_CTRL, 32'h6);
      @(posedge clk) pin_level <= 1;
      wr(ADDR_CTRL, 32'h7);
      wait_st(ST_ASLEEP, 40);
      `CHK("entry time", 2 * (SETTLE_CYC + 1) + 1, n)
      repeat (30) @(negedge clk);
      `CHK("awake edge", ST_ASLEEP, state_out)
      @(posedge clk) pin_level <= 0;
      repeat (5) @(negedge clk);
      `CHK("wrong edge", ST_ASLEEP, state_out)
      @(posedge clk) pin_level <= 1;
      wait_st(ST_POWER_UP, 5);
      `CHK("pin wake", ST_POWER_UP, state_out)
      wait_st(ST_AWAKE, 30);
      `CHK("wake time", 2 * (SETTLE_CYC + 1), n)
      foreach (mdl[i]) begin
         rd(ADDR_DSM_BASE + 8'(4 * i), d);
         `CHK("sleep memory", mdl[i], d)
      end
      rd(ADDR_IRQ_STAT, d);
      `CHK("irq status", 32'h3, d)
      `CHK("irq masked", 1'b0, irq)
      wr(ADDR_IRQ_MASK, 32'h2);
      @(negedge clk);
      `CHK("irq on", 1'b1, irq)
      wr(ADDR_IRQ_STAT, 32'hF);
      @(negedge clk);
      `CHK("irq clear", 1'b0, irq)
      // USB sleep, wake arriving during entry stays pending
      wr(ADDR_CTRL, 32'h10);
      usb(1);
      repeat (3) @(negedge clk);
      `CHK("usb wake awake", ST_AWAKE, state_out)
      usb(0);
      wait_st(ST_CLK_OFF, 5);
      `CHK("usb sleep", ST_CLK_OFF, state_out)
      usb(1);
      wait_st(ST_ASLEEP, 30);
      @(negedge clk);
      `CHK("pending wake", ST_POWER_UP, state_out)
      wait_st(ST_AWAKE, 30);
      // Counter match wake
      wr(ADDR_CTRL, 32'h8);
      rd(ADDR_CNT_HI, d2);
      rd(ADDR_CNT_LO, d);
      t0 = cyc;
      wr(ADDR_WAKE_HI, d2);
      wr(ADDR_WAKE_LO, d + 32'd150);
      wr(ADDR_CTRL, 32'h9);
      wait_st(ST_ASLEEP, 30);
      wait_st(ST_POWER_UP, 200);
      `CHK("timer wake", 1'b1, (cyc - t0) inside {[149:153]})
      wait_st(ST_AWAKE, 30);
      rd(ADDR_IRQ_STAT, d);
      `CHK("timer flag", 1'b1, d[IRQ_TIMER_BIT])
      // Slow oscillator with random increment
      incr = $urandom_range(255, 1);
      wr(ADDR_INCR, incr);
      @(posedge clk) pin_level <= 0;
      wr(ADDR_CTRL, 32'h26);
      wr(ADDR_CTRL, 32'h27);
      wait_st(ST_ASLEEP, 30);
      rd(ADDR_STATUS, d);
      `CHK("on slow", 5'h0F, d[4:0])
      rd(ADDR_CNT_LO, d);
      repeat (318) @(posedge clk);
      rd(ADDR_CNT_LO, d2);
      `CHK("slow step", incr, d2 - d)
      @(posedge clk) pin_level <= 1;
      wait_st(ST_AWAKE, 40);
      // Supply loss in mid-entry
      wr(ADDR_CTRL, 32'h1);
      wait_st(ST_PWR_DOWN, 20);
      @(posedge clk) supply_ok <= 0;
      @(posedge clk) supply_ok <= 1;
      @(negedge clk);
      `CHK("supply reset", 1'b1, pwr.sys_reset)
      `CHK("supply state", ST_POWER_UP, state_out)
      wait_st(ST_AWAKE, 30);
      wr(ADDR_IRQ_MASK, 32'h4);
      @(negedge clk);
      `CHK("supply irq", 1'b1, irq)
      // Wake on a falling pin, then on a direct USB exit
      wr(ADDR_CTRL, 32'h3);
      wait_st(ST_ASLEEP, 30);
      @(posedge clk) pin_level <= 0;
      wait_st(ST_POWER_UP, 5);
      `CHK("low pin wake", ST_POWER_UP, state_out)
      wait_st(ST_AWAKE, 30);
      wr(ADDR_CTRL, 32'h11);
      wait_st(ST_ASLEEP, 30);
      usb(1);
      wait_st(ST_POWER_UP, 5);
      `CHK("usb wake", ST_POWER_UP, state_out)
      summarize();
   end
endmodule

bind swpc_ctrl swpc_assertions chk (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
   .usb_standby_enter(usb_standby_enter), .usb_standby_exit(usb_standby_exit), .wake_pin(wake_pin),
   .power_good(power_good), .pwr(pwr), .state_out(state_out), .irq(irq));
